/* pkg/hsac_defs.svh */
// Register offsets, field positions, reset values and angle constants for the Hall sector angle corrector
`ifndef HSAC_DEFS_SVH
`define HSAC_DEFS_SVH

// ============================================================
// Register offsets
`define HSAC_MODE_ADDR      8'h02
`define HSAC_PORT_EN_ADDR   8'h0b
`define HSAC_TOL_ADDR       8'h2e
`define HSAC_CW_OFF_ADDR    8'hf8
`define HSAC_CCW_OFF_ADDR   8'hf9
`define HSAC_STATUS_ADDR    8'hfa

// ============================================================
// Field positions
`define HSAC_DIR_BIT        6
`define HSAC_HALL_EN_HI     4
`define HSAC_HALL_EN_LO     2

// ============================================================
// Reset values
`define HSAC_MODE_RST       8'h00
`define HSAC_PORT_EN_RST    8'h00
`define HSAC_TOL_RST        8'h00
`define HSAC_CW_OFF_RST     8'h00
`define HSAC_CCW_OFF_RST    8'h00

// ============================================================
// Angle constants, full turn is 2^16 counts
`define HSAC_SECTOR_SPAN    17'h02aab
`define HSAC_HALF_TURN      16'h8000
`define HSAC_FULL_TURN      17'h10000
`define HSAC_CODE_LOW_BAD   3'h0
`define HSAC_CODE_HIGH_BAD  3'h7

`endif

/* pkg/hsac_pkg.sv */
// Types shared by the Hall sector angle corrector
package hsac_pkg;

    // ============================================================
    // Software visible configuration
    typedef struct packed {
        logic [7:0] motor_mode_config;
        logic [7:0] port_function_enable;
        logic [7:0] sector_tolerance;
        logic [7:0] cw_angle_offset;
        logic [7:0] ccw_angle_offset;
    } hsac_cfg_t;

    // ============================================================
    // Result of one correction step
    typedef struct packed {
        logic [15:0] angle;
        logic        valid;
        logic        corrected;
        logic        code_bad;
    } hsac_res_t;

endpackage : hsac_pkg

/* src/hsac_top.sv */
// Hall sector angle corrector: Hall sync, sector check, angle clamp, speed pulse, registers
`timescale 1ns/1ns
`include "hsac_defs.svh"

module hsac_top
    import hsac_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        position_input_1,
    input  wire logic        position_input_2,
    input  wire logic        position_input_3,
    input  wire logic [15:0] est_angle,
    input  wire logic        est_valid,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata_ff,
    output logic      [15:0] angle_out_ff,
    output logic             angle_valid_ff,
    output logic             angle_corrected_ff,
    output logic             hall_code_err_ff,
    output logic             speed_pulse_output_ff
);

    // ============================================================
    // Helpers
    // v/255 of a full 2^16 turn is v*257 to within one count
    function automatic logic [15:0] hsac_scale(input logic [7:0] v);
        hsac_scale = {v, v};
    endfunction : hsac_scale

    // Map a Hall code to its position in the rotation sequence; 7 means illegal
    function automatic logic [2:0] hsac_sector(input logic [2:0] code, input logic ccw);
        logic [2:0] idx;
        idx = 3'h7;
        if (!ccw) begin
            unique case (code)
                3'b001:  idx = 3'h0;
                3'b101:  idx = 3'h1;
                3'b100:  idx = 3'h2;
                3'b110:  idx = 3'h3;
                3'b010:  idx = 3'h4;
                3'b011:  idx = 3'h5;
                default: idx = 3'h7;
            endcase
        end else begin
            unique case (code)
                3'b001:  idx = 3'h0;
                3'b011:  idx = 3'h1;
                3'b010:  idx = 3'h2;
                3'b110:  idx = 3'h3;
                3'b100:  idx = 3'h4;
                3'b101:  idx = 3'h5;
                default: idx = 3'h7;
            endcase
        end
        hsac_sector = idx;
    endfunction : hsac_sector

    // ============================================================
    // Hall input synchronisers; first stage feeds only the second
    logic [2:0] hall_meta_ff;
    logic [2:0] hall_sync_ff;
    logic [2:0] nxt_hall_meta;
    logic [2:0] nxt_hall_sync;

    always_comb begin
        nxt_hall_meta = {position_input_3, position_input_2, position_input_1};
        nxt_hall_sync = hall_meta_ff;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hall_meta_ff <= 3'h0;
            hall_sync_ff <= 3'h0;
        end else begin
            hall_meta_ff <= nxt_hall_meta;
            hall_sync_ff <= nxt_hall_sync;
        end
    end

    // ============================================================
    // Register file
    hsac_cfg_t  cfg_ff;
    hsac_cfg_t  nxt_cfg;
    logic [7:0] nxt_rdata;
    logic       dir_ccw;
    logic       hall_on;
    logic [2:0] sect_idx;

    assign dir_ccw = cfg_ff.motor_mode_config[`HSAC_DIR_BIT];
    assign hall_on = |cfg_ff.port_function_enable[`HSAC_HALL_EN_HI:`HSAC_HALL_EN_LO];

    // Writes land next edge; reads answer at that same edge, unmapped reads zero
    always_comb begin
        nxt_cfg   = cfg_ff;
        nxt_rdata = reg_rdata_ff;
        if (reg_wr) begin
            unique case (reg_addr)
                `HSAC_MODE_ADDR:    nxt_cfg.motor_mode_config    = reg_wdata;
                `HSAC_PORT_EN_ADDR: nxt_cfg.port_function_enable = reg_wdata;
                `HSAC_TOL_ADDR:     nxt_cfg.sector_tolerance     = reg_wdata;
                `HSAC_CW_OFF_ADDR:  nxt_cfg.cw_angle_offset      = reg_wdata;
                `HSAC_CCW_OFF_ADDR: nxt_cfg.ccw_angle_offset     = reg_wdata;
                default:            nxt_cfg = cfg_ff;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `HSAC_MODE_ADDR:    nxt_rdata = cfg_ff.motor_mode_config;
                `HSAC_PORT_EN_ADDR: nxt_rdata = cfg_ff.port_function_enable;
                `HSAC_TOL_ADDR:     nxt_rdata = cfg_ff.sector_tolerance;
                `HSAC_CW_OFF_ADDR:  nxt_rdata = cfg_ff.cw_angle_offset;
                `HSAC_CCW_OFF_ADDR: nxt_rdata = cfg_ff.ccw_angle_offset;
                `HSAC_STATUS_ADDR:  nxt_rdata = {1'b0, hall_code_err_ff, sect_idx, hall_sync_ff};
                default:            nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ff       <= {`HSAC_MODE_RST, `HSAC_PORT_EN_RST, `HSAC_TOL_RST,
                             `HSAC_CW_OFF_RST, `HSAC_CCW_OFF_RST};
            reg_rdata_ff <= 8'h00;
        end else begin
            cfg_ff       <= nxt_cfg;
            reg_rdata_ff <= nxt_rdata;
        end
    end

    // ============================================================
    // Sector window: start + offset, widened by tolerance on both sides
    logic [15:0] tol_ang;
    logic [15:0] off_ang;
    logic [15:0] sect_start;
    logic [15:0] win_lo;
    logic [16:0] win_span;
    logic [17:0] span_sum;
    logic [15:0] rel;
    logic [16:0] over_top;
    logic [16:0] under_lo;
    logic        code_ok;
    logic        in_win;

    assign sect_idx = hsac_sector(hall_sync_ff, dir_ccw);
    assign code_ok  = (sect_idx != 3'h7);
    assign tol_ang  = hsac_scale(cfg_ff.sector_tolerance);
    // Offset follows the direction bit
    assign off_ang  = dir_ccw ? hsac_scale(cfg_ff.ccw_angle_offset)
                              : hsac_scale(cfg_ff.cw_angle_offset);

    // Counter-clockwise sectors are walked downward, sector 0 starting five spans up
    always_comb begin
        logic [2:0]  pos;
        logic [19:0] prod;
        pos        = dir_ccw ? 3'(3'h5 - sect_idx) : sect_idx;
        prod       = `HSAC_SECTOR_SPAN * pos;
        sect_start = prod[15:0];
    end

    assign win_lo   = 16'(sect_start + off_ang - tol_ang);
    // Two large tolerances overflow 17 bits, so saturate the span at one full turn
    assign span_sum = {1'b0, `HSAC_SECTOR_SPAN} + {2'b00, tol_ang} + {2'b00, tol_ang};
    assign win_span = (span_sum >= {1'b0, `HSAC_FULL_TURN}) ? `HSAC_FULL_TURN : span_sum[16:0];
    assign rel      = 16'(est_angle - win_lo);
    assign over_top = 17'({1'b0, rel} - win_span);
    assign under_lo = 17'(`HSAC_FULL_TURN - {1'b0, rel});
    // A span past a full turn covers every angle, so nothing is ever clamped
    assign in_win   = win_span[16] || ({1'b0, rel} <= win_span);

    // ============================================================
    // Correction stage
    hsac_res_t res_ff;
    hsac_res_t nxt_res;
    logic      nxt_pulse;

    // Illegal Hall codes (wire break, all high) leave the estimate alone
    always_comb begin
        nxt_res.valid     = est_valid;
        nxt_res.angle     = res_ff.angle;
        nxt_res.corrected = 1'b0;
        nxt_res.code_bad  = ~code_ok;
        if (est_valid) begin
            nxt_res.angle = est_angle;
            if (hall_on && code_ok && !in_win) begin
                nxt_res.corrected = 1'b1;
                nxt_res.angle     = (over_top < under_lo) ? 16'(win_lo + win_span[15:0]) : win_lo;
            end
        end
        // High over the upper half turn, so it falls when the angle wraps to zero
        nxt_pulse = (nxt_res.angle >= `HSAC_HALF_TURN);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            res_ff                <= '0;
            speed_pulse_output_ff <= 1'b0;
        end else begin
            res_ff                <= nxt_res;
            speed_pulse_output_ff <= nxt_pulse;
        end
    end

    assign angle_out_ff       = res_ff.angle;
    assign angle_valid_ff     = res_ff.valid;
    assign angle_corrected_ff = res_ff.corrected;
    assign hall_code_err_ff   = res_ff.code_bad;

    // ============================================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_speed_fall;
        $fell(speed_pulse_output_ff) |-> angle_out_ff < `HSAC_HALF_TURN;
    endproperty
    a_speed_fall: assert property (p_speed_fall) else $error("speed pulse fell away from zero");

    property p_pass_when_off;
        est_valid && !hall_on |=> angle_out_ff == $past(est_angle) && !angle_corrected_ff;
    endproperty
    a_pass_when_off: assert property (p_pass_when_off) else $error("angle altered while assist off");

    property p_pass_in_window;
        est_valid && hall_on && code_ok && in_win |=> angle_out_ff == $past(est_angle);
    endproperty
    a_pass_in_window: assert property (p_pass_in_window) else $error("in-window angle altered");

    property p_clamp_out;
        est_valid && hall_on && code_ok && !in_win
            |=> angle_corrected_ff && angle_valid_ff && angle_out_ff != $past(est_angle);
    endproperty
    a_clamp_out: assert property (p_clamp_out) else $error("out-of-window angle not pulled back");

    property p_tol_scale;
        tol_ang == 16'(cfg_ff.sector_tolerance) * 16'h0101;
    endproperty
    a_tol_scale: assert property (p_tol_scale) else $error("tolerance scaling wrong");

    property p_cw_offset;
        !dir_ccw |-> off_ang == 16'(cfg_ff.cw_angle_offset) * 16'h0101;
    endproperty
    a_cw_offset: assert property (p_cw_offset) else $error("clockwise offset not applied");

    property p_ccw_offset;
        dir_ccw |-> off_ang == 16'(cfg_ff.ccw_angle_offset) * 16'h0101;
    endproperty
    a_ccw_offset: assert property (p_ccw_offset) else $error("counterclockwise offset not applied");

    property p_cw_order;
        !dir_ccw && hall_sync_ff == 3'b101 |-> sect_idx == 3'h1;
    endproperty
    a_cw_order: assert property (p_cw_order) else $error("clockwise sector order wrong");

    property p_ccw_order;
        dir_ccw && hall_sync_ff == 3'b011 |-> sect_idx == 3'h1;
    endproperty
    a_ccw_order: assert property (p_ccw_order) else $error("counterclockwise sector order wrong");

    property p_dir_write;
        reg_wr && reg_addr == `HSAC_MODE_ADDR |=> dir_ccw == $past(reg_wdata[`HSAC_DIR_BIT]);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction bit not taken");

    property p_bad_code;
        est_valid && (hall_sync_ff == `HSAC_CODE_LOW_BAD || hall_sync_ff == `HSAC_CODE_HIGH_BAD)
            |=> hall_code_err_ff && !angle_corrected_ff;
    endproperty
    a_bad_code: assert property (p_bad_code) else $error("illegal Hall code not flagged");

    property p_valid_follow;
        angle_valid_ff == $past(est_valid);
    endproperty
    a_valid_follow: assert property (p_valid_follow) else $error("valid flag lagging wrong");

    // From tolerance 0x6b up the widened window covers the whole turn
    property p_wide_tol;
        est_valid && cfg_ff.sector_tolerance >= 8'h6b |=> !angle_corrected_ff;
    endproperty
    a_wide_tol: assert property (p_wide_tol) else $error("clamped inside a full-turn window");

    property p_status_read;
        reg_rd && reg_addr == `HSAC_STATUS_ADDR |=> reg_rdata_ff[2:0] == $past(hall_sync_ff);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status misses the Hall code");

    // Main scenarios
    c_clamp_cw:   cover property (est_valid && hall_on && !dir_ccw && code_ok && !in_win);
    c_clamp_ccw:  cover property (est_valid && hall_on && dir_ccw && code_ok && !in_win);
    c_speed_fall: cover property ($fell(speed_pulse_output_ff));
    c_clamp_high: cover property (est_valid && hall_on && code_ok && !in_win && over_top < under_lo);
    c_bad_code:   cover property (est_valid && !code_ok);

endmodule : hsac_top

/* testbench/hsac_hall_model.sv */
// Model of three Hall sensors spaced 120 electrical degrees apart
`timescale 1ns/1ns
module hsac_hall_model (
    input  wire logic [2:0] sector_sel,
    input  wire logic       ccw,
    output logic            position_input_1,
    output logic            position_input_2,
    output logic            position_input_3
);
    logic [2:0] code;

    // ============================================================
    // Sector code table, sensor3 in the top bit; selects 6 and 7 give broken codes
    always_comb begin
        case (sector_sel)
            3'h0: code = 3'h1;
            3'h1: code = ccw ? 3'h3 : 3'h5;
            3'h2: code = ccw ? 3'h2 : 3'h4;
            3'h3: code = 3'h6;
            3'h4: code = ccw ? 3'h4 : 3'h2;
            3'h5: code = ccw ? 3'h5 : 3'h3;
            3'h6: code = 3'h0;
            default: code = 3'h7;
        endcase
    end

    // Sensors always drive, so the pull-ups never show
    assign {position_input_3, position_input_2, position_input_1} = code;
endmodule : hsac_hall_model

/* testbench/hsac_top_bench.sv */
// Self-checking bench for the Hall sector angle corrector
`timescale 1ns/1ns
`include "hsac_defs.svh"
module hsac_top_bench;
    import hsac_pkg::*;
    localparam int SPAN = 10923; // One sixth of a turn in angle counts
    logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, est_valid = 1'b0, ccw = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_ff;
    logic [15:0] est_angle = 16'h0000, angle_out_ff, e;
    logic [2:0] sector_sel = 3'h0;
    logic p1, p2, p3, angle_valid_ff, angle_corrected_ff, hall_code_err_ff, speed_pulse_output_ff;
    int n_mismatch = 0, n_tests = 0;
    logic [7:0] addrs [5] = '{`HSAC_MODE_ADDR, `HSAC_PORT_EN_ADDR, `HSAC_TOL_ADDR, `HSAC_CW_OFF_ADDR,
                             `HSAC_CCW_OFF_ADDR};

    always #2 core_clk = ~core_clk;

    hsac_hall_model hsac_hall_model_inst (.sector_sel(sector_sel), .ccw(ccw), .position_input_1(p1),
        .position_input_2(p2), .position_input_3(p3));
    hsac_top hsac_top_inst (.core_clk(core_clk), .rst_n(rst_n), .position_input_1(p1), .position_input_2(p2),
        .position_input_3(p3), .est_angle(est_angle), .est_valid(est_valid), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .angle_out_ff(angle_out_ff),
        .angle_valid_ff(angle_valid_ff), .angle_corrected_ff(angle_corrected_ff),
        .hall_code_err_ff(hall_code_err_ff), .speed_pulse_output_ff(speed_pulse_output_ff));

    // ============================================================
    // Helpers
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data is registered at the edge that takes the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 check("register", {8'h00, exp}, {8'h00, reg_rdata_ff});
    endtask : rd

    // Two sync flops sit in front of the sector logic, so give the code time to land
    task automatic set_sector(input logic [2:0] k);
        @(posedge core_clk);
        sector_sel <= k;
        repeat (4) @(posedge core_clk);
    endtask : set_sector

    task automatic sample(input logic [15:0] est, input logic [15:0] exp, input logic err);
        @(posedge core_clk);
        est_valid <= 1'b1; est_angle <= est;
        @(posedge core_clk);
        est_valid <= 1'b0;
        #1 check("angle", exp, angle_out_ff);
        check("corrected", {15'h0, exp !== est}, {15'h0, angle_corrected_ff});
        check("valid", 16'h0001, {15'h0, angle_valid_ff});
        check("code error", {15'h0, err}, {15'h0, hall_code_err_ff});
        check("speed pulse", {15'h0, exp[15]}, {15'h0, speed_pulse_output_ff});
    endtask : sample

    // Expected clamp, worked out independently from the sector layout
    function automatic logic [15:0] expect_angle(input logic [15:0] est, input int k, input logic dir,
                                                 input logic [7:0] tol, input logic [7:0] off);
        logic [15:0] lo;
        logic [16:0] span;
        logic [16:0] rel;
        lo = 16'((dir ? 5 - k : k) * SPAN + off * 257 - tol * 257);
        span = (SPAN + tol * 514 > 65535) ? 17'h10000 : 17'(SPAN + tol * 514);
        rel = {1'b0, 16'(est - lo)};
        if (span >= 17'h10000 || rel <= span) return est;
        if ((rel - span) < (17'h10000 - rel)) return 16'(lo + span);
        return lo;
    endfunction : expect_angle

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done

    initial begin
        #40000 n_mismatch++;
        test_done();
    end

    // ============================================================
    // Main sequence
    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (addrs[i]) rd(addrs[i], 8'h00);
        foreach (addrs[i]) wr(addrs[i], 8'h11 * (i + 1));
        wr(8'h10, 8'h55);
        wr(`HSAC_STATUS_ADDR, 8'h55);
        foreach (addrs[i]) rd(addrs[i], 8'h11 * (i + 1));
        rd(8'h10, 8'h00);
        rd(`HSAC_STATUS_ADDR, 8'h01);
        foreach (addrs[i]) wr(addrs[i], 8'h00);
        // Assist cleared: estimate passes untouched, pulse falls on wrap to zero
        sample(16'hf000, 16'hf000, 1'b0);
        sample(16'h0000, 16'h0000, 1'b0);
        wr(`HSAC_PORT_EN_ADDR, 8'h04);
        wr(`HSAC_TOL_ADDR, 8'h08);
        wr(`HSAC_CW_OFF_ADDR, 8'h40);
        wr(`HSAC_CCW_OFF_ADDR, 8'h80);
        // Every sector in both directions: inside, above and below the widened window
        for (int d = 0; d < 2; d++) begin
            wr(`HSAC_MODE_ADDR, d ? 8'h40 : 8'h00);
            ccw <= d[0];
            for (int k = 0; k < 6; k++) begin
                set_sector(3'(k));
                e = 16'((d ? 5 - k : k) * SPAN + (d ? 8'h80 : 8'h40) * 257);
                sample(e + 16'h1555, expect_angle(e + 16'h1555, k, d[0], 8'h08, d ? 8'h80 : 8'h40), 1'b0);
                sample(e + 16'h3400, expect_angle(e + 16'h3400, k, d[0], 8'h08, d ? 8'h80 : 8'h40), 1'b0);
                sample(e - 16'h0900, expect_angle(e - 16'h0900, k, d[0], 8'h08, d ? 8'h80 : 8'h40), 1'b0);
            end
        end
        // Tolerance near a full turn opens the window everywhere
        wr(`HSAC_TOL_ADDR, 8'hf0);
        sample(e + 16'h8000, expect_angle(e + 16'h8000, 5, 1'b1, 8'hf0, 8'h80), 1'b0);
        // Broken codes leave the estimate alone and flag it
        set_sector(3'h7);
        sample(16'h3000, 16'h3000, 1'b1);
        set_sector(3'h6);
        sample(16'h9000, 16'h9000, 1'b1);
        rd(`HSAC_STATUS_ADDR, 8'h78);
        check("valid idle", 16'h0000, {15'h0, angle_valid_ff});
        test_done();
    end
endmodule : hsac_top_bench
